// ==== core/capcmp_pkg.sv ====
package capcmp_pkg;
    // register word offsets (byte addresses), all chosen here
    localparam logic [7:0] ADDR_UNIT_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_MATCH_LOW = 8'h04;
    localparam logic [7:0] ADDR_MATCH_HIGH = 8'h08;
    localparam logic [7:0] ADDR_PERIOD = 8'h0c;
    localparam logic [7:0] ADDR_TIMER_TWO_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_FLAGS = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h18;
    // unit control fields
    localparam int MODE_LSB = 0;
    localparam int DUTY_LOW_LSB = 4;
    localparam logic [5:0] UNIT_CONTROL_RESET = 6'h00;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    // timer two control fields
    localparam int PRESCALE_LSB = 0;
    localparam int TIMER_TWO_ON_BIT = 2;
    // flags register bits
    localparam int FLAG_EVENT_BIT = 0;
    localparam int FLAG_GO_BIT = 1;
    // mode select encodings
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CMP_TOGGLE = 4'h2;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_SWINT = 4'ha;
    localparam logic [3:0] MODE_CMP_TRIGGER = 4'hb;
    localparam logic [3:0] MODE_PWM = 4'hc;
    // oscillator periods per instruction cycle
    localparam int OSC_PER_TICK = 4;

    typedef enum logic [2:0] {
        ACT_NONE, ACT_TOGGLE, ACT_SET, ACT_CLEAR, ACT_SWINT, ACT_TRIGGER, ACT_PWM
    } action_t;
endpackage

// ==== core/pwm_timebase_if.sv ====
`timescale 1ns/1ps
interface pwm_timebase_if;
    logic run;
    logic [1:0] prescale;
    logic [7:0] period;
    logic [7:0] count;
    logic [1:0] sub;
    logic periodEnd;
    modport timebase (input run, prescale, period, output count, sub, periodEnd);
    modport user (output run, prescale, period, input count, sub, periodEnd);
endinterface

// ==== core/pwm_timebase.sv ====
`timescale 1ns/1ps
// 8-bit timer two with prescaler; a 10-bit base is count:sub
module pwm_timebase (
    input wire logic clk_sys,
    input wire logic reset,
    pwm_timebase_if.timebase tb
);
    logic [5:0] preCnt_reg;
    logic [7:0] count_reg;
    logic [1:0] sub_reg;
    logic periodEnd_reg;
    logic [5:0] preMax;

    // prescale codes 1:1, 1:4, 1:16; the postscaler is not present at all
    always_comb begin
        unique case (tb.prescale)
            2'b00: preMax = 6'h03;
            2'b01: preMax = 6'h0f;
            default: preMax = 6'h3f;
        endcase
    end

    // one count per four oscillator periods times prescale
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            preCnt_reg <= 6'h00;
            count_reg <= 8'h00;
            periodEnd_reg <= 1'b0;
        end else begin
            periodEnd_reg <= 1'b0;
            if (!tb.run) begin
                preCnt_reg <= 6'h00;
            end else if (preCnt_reg >= preMax) begin
                preCnt_reg <= 6'h00;
                if (count_reg == tb.period) begin
                    count_reg <= 8'h00;
                    periodEnd_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + 8'h01;
                end
            end else begin
                preCnt_reg <= preCnt_reg + 6'h01;
            end
        end
    end

    // two low bits from the prescaler's top bits
    always_comb begin
        unique case (tb.prescale)
            2'b00: sub_reg = preCnt_reg[1:0];
            2'b01: sub_reg = preCnt_reg[3:2];
            default: sub_reg = preCnt_reg[5:4];
        endcase
    end

    assign tb.count = count_reg;
    assign tb.sub = sub_reg;
    assign tb.periodEnd = periodEnd_reg;
endmodule // pwm_timebase

// ==== core/compare_and_pwm_unit.sv ====
`timescale 1ns/1ps
//------------------------------------------------
// rule summary
//------------------------------------------------
module compare_and_pwm_unit #(
    parameter bit SECOND_UNIT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [15:0] timerOneCount,
    input wire logic timerOneTick,
    input wire logic converterEnable,
    output logic timerOneReset,
    output logic timerOneOverflowSet,
    output logic converterGo,
    output logic unitEvent,
    output logic pinOut,
    output logic pinOwned
);
    //------------------------------------------------
    // registers
    //------------------------------------------------
    logic [5:0] unitControl_reg;
    logic [7:0] matchLow_reg;
    logic [7:0] matchHigh_reg;
    logic [7:0] period_reg;
    logic [2:0] timerTwoControl_reg;
    logic eventFlag_reg;
    logic goFlag_reg;
    logic [1:0] dutyLatch_reg;
    logic cmpLatch_reg;
    logic pwmPin_reg;
    logic trigger_reg;
    logic resetPending_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic timerOneReset_reg;
    logic unitEvent_reg;
    logic pinOut_reg;
    logic pinOwned_reg;
    logic matchPrev_reg;

    // local names for the shared action codes
    typedef capcmp_pkg::action_t action_t;
    localparam action_t ACT_NONE = capcmp_pkg::ACT_NONE;
    localparam action_t ACT_TOGGLE = capcmp_pkg::ACT_TOGGLE;
    localparam action_t ACT_SET = capcmp_pkg::ACT_SET;
    localparam action_t ACT_CLEAR = capcmp_pkg::ACT_CLEAR;
    localparam action_t ACT_SWINT = capcmp_pkg::ACT_SWINT;
    localparam action_t ACT_TRIGGER = capcmp_pkg::ACT_TRIGGER;
    localparam action_t ACT_PWM = capcmp_pkg::ACT_PWM;

    logic [3:0] mode;
    action_t act;
    logic [15:0] matchValue;
    logic match;
    logic matchRise;
    logic wrEn;
    logic rdEn;
    logic ctrlWrite;
    logic [9:0] dutyActive;
    logic [9:0] timeBase;
    logic [9:0] dutyNew;
    logic addrOk;

    pwm_timebase_if tbi ();

    function automatic action_t decode(input logic [3:0] m);
        unique case (m)
            capcmp_pkg::MODE_CMP_TOGGLE: decode = ACT_TOGGLE;
            capcmp_pkg::MODE_CMP_SET: decode = ACT_SET;
            capcmp_pkg::MODE_CMP_CLEAR: decode = ACT_CLEAR;
            capcmp_pkg::MODE_CMP_SWINT: decode = ACT_SWINT;
            capcmp_pkg::MODE_CMP_TRIGGER: decode = ACT_TRIGGER;
            capcmp_pkg::MODE_PWM: decode = ACT_PWM;
            default: decode = ACT_NONE;
        endcase
    endfunction

    assign mode = unitControl_reg[capcmp_pkg::MODE_LSB +: 4];
    assign act = decode(mode);
    assign matchValue = {matchHigh_reg, matchLow_reg};
    assign match = (act != ACT_NONE) && (act != ACT_PWM) && (matchValue == timerOneCount);
    assign matchRise = match && !matchPrev_reg;
    assign wrEn = psel && penable && pwrite && pready_reg;
    assign rdEn = psel && !penable && !pwrite;
    assign ctrlWrite = wrEn && (paddr == capcmp_pkg::ADDR_UNIT_CONTROL);
    assign dutyNew = {matchLow_reg, unitControl_reg[capcmp_pkg::DUTY_LOW_LSB +: 2]};
    assign dutyActive = {matchHigh_reg, dutyLatch_reg};
    assign timeBase = {tbi.count, tbi.sub};
    assign addrOk = paddr inside {capcmp_pkg::ADDR_UNIT_CONTROL, capcmp_pkg::ADDR_MATCH_LOW,
        capcmp_pkg::ADDR_MATCH_HIGH, capcmp_pkg::ADDR_PERIOD,
        capcmp_pkg::ADDR_TIMER_TWO_CONTROL, capcmp_pkg::ADDR_FLAGS, capcmp_pkg::ADDR_STATUS};

    assign tbi.run = (act == ACT_PWM) && timerTwoControl_reg[capcmp_pkg::TIMER_TWO_ON_BIT];
    assign tbi.prescale = timerTwoControl_reg[capcmp_pkg::PRESCALE_LSB +: 2];
    assign tbi.period = period_reg;

    pwm_timebase u_timebase (
        .clk_sys(clk_sys),
        .reset(reset),
        .tb(tbi.timebase)
    );

    //------------------------------------------------
    // apb slave, answers in the access cycle
    //------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end else begin
            pready_reg <= psel && !penable;
            pslverr_reg <= psel && !penable && !addrOk;
            if (rdEn) begin
                unique case (paddr)
                    capcmp_pkg::ADDR_UNIT_CONTROL: prdata_reg <= {26'h0, unitControl_reg};
                    capcmp_pkg::ADDR_MATCH_LOW: prdata_reg <= {24'h0, matchLow_reg};
                    capcmp_pkg::ADDR_MATCH_HIGH: prdata_reg <= {24'h0, matchHigh_reg};
                    capcmp_pkg::ADDR_PERIOD: prdata_reg <= {24'h0, period_reg};
                    capcmp_pkg::ADDR_TIMER_TWO_CONTROL: prdata_reg <= {29'h0, timerTwoControl_reg};
                    capcmp_pkg::ADDR_FLAGS: prdata_reg <= {30'h0, goFlag_reg, eventFlag_reg};
                    capcmp_pkg::ADDR_STATUS: prdata_reg <= {22'h0, tbi.count, pinOut_reg,
                        pinOwned_reg};
                    default: prdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // configuration writes
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            unitControl_reg <= capcmp_pkg::UNIT_CONTROL_RESET;
            matchLow_reg <= 8'h00;
            period_reg <= capcmp_pkg::PERIOD_RESET;
            timerTwoControl_reg <= 3'h0;
        end else if (wrEn) begin
            unique case (paddr)
                capcmp_pkg::ADDR_UNIT_CONTROL: unitControl_reg <= pwdata[5:0];
                capcmp_pkg::ADDR_MATCH_LOW: matchLow_reg <= pwdata[7:0];
                capcmp_pkg::ADDR_PERIOD: period_reg <= pwdata[7:0];
                capcmp_pkg::ADDR_TIMER_TWO_CONTROL: timerTwoControl_reg <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // high match: software in compare, duty buffer in pwm
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            matchHigh_reg <= 8'h00;
            dutyLatch_reg <= 2'b00;
        end else if (act == ACT_PWM) begin
            if (tbi.periodEnd) begin
                matchHigh_reg <= dutyNew[9:2];
                dutyLatch_reg <= dutyNew[1:0];
            end
        end else if (wrEn && paddr == capcmp_pkg::ADDR_MATCH_HIGH) begin
            matchHigh_reg <= pwdata[7:0];
        end
    end

    //------------------------------------------------
    // compare actions
    //------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            matchPrev_reg <= 1'b0;
            cmpLatch_reg <= 1'b0;
        end else begin
            matchPrev_reg <= match;
            if (ctrlWrite && pwdata[5:0] == 6'h00) begin
                cmpLatch_reg <= 1'b0;
            end else if (matchRise) begin
                unique case (act)
                    ACT_TOGGLE: cmpLatch_reg <= !cmpLatch_reg;
                    ACT_SET: cmpLatch_reg <= 1'b1;
                    ACT_CLEAR: cmpLatch_reg <= 1'b0;
                    default: ;
                endcase
            end
        end
    end

    // event and go flags: set wins over clear
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            eventFlag_reg <= 1'b0;
            goFlag_reg <= 1'b0;
        end else begin
            if (matchRise) begin
                eventFlag_reg <= 1'b1;
            end else if (wrEn && paddr == capcmp_pkg::ADDR_FLAGS
                && pwdata[capcmp_pkg::FLAG_EVENT_BIT]) begin
                eventFlag_reg <= 1'b0;
            end
            if (SECOND_UNIT && matchRise && act == ACT_TRIGGER && converterEnable) begin
                goFlag_reg <= 1'b1;
            end else if (wrEn && paddr == capcmp_pkg::ADDR_FLAGS
                && pwdata[capcmp_pkg::FLAG_GO_BIT]) begin
                goFlag_reg <= 1'b0;
            end
        end
    end

    // trigger now, timer reset at the next timer tick if match still holds
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            trigger_reg <= 1'b0;
            resetPending_reg <= 1'b0;
            timerOneReset_reg <= 1'b0;
        end else begin
            trigger_reg <= matchRise && act == ACT_TRIGGER;
            timerOneReset_reg <= 1'b0;
            if (matchRise && act == ACT_TRIGGER) begin
                resetPending_reg <= 1'b1;
            end else if (resetPending_reg && !match) begin
                resetPending_reg <= 1'b0;
            end else if (resetPending_reg && timerOneTick) begin
                resetPending_reg <= 1'b0;
                timerOneReset_reg <= 1'b1;
            end
        end
    end

    //------------------------------------------------
    // pwm pin
    //------------------------------------------------
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pwmPin_reg <= 1'b0;
        end else if (act != ACT_PWM) begin
            pwmPin_reg <= 1'b0;
        end else if (tbi.periodEnd) begin
            pwmPin_reg <= (dutyNew != 10'h000);
        end else if (timeBase == dutyActive && tbi.run) begin
            pwmPin_reg <= 1'b0;
        end
    end

    // outputs all registered; pin released in off and non-pin modes
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            pinOut_reg <= 1'b0;
            pinOwned_reg <= 1'b0;
            unitEvent_reg <= 1'b0;
        end else begin
            pinOwned_reg <= act inside {ACT_TOGGLE, ACT_SET, ACT_CLEAR, ACT_PWM};
            pinOut_reg <= (act == ACT_PWM) ? pwmPin_reg : cmpLatch_reg;
            unitEvent_reg <= eventFlag_reg;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign timerOneReset = timerOneReset_reg;
    assign timerOneOverflowSet = 1'b0;
    assign converterGo = goFlag_reg;
    assign unitEvent = unitEvent_reg;
    assign pinOut = pinOut_reg;
    assign pinOwned = pinOwned_reg;

    //------------------------------------------------
    // checks
    //------------------------------------------------
    property p_flag;
        @(posedge clk_sys) disable iff (reset) matchRise |=> eventFlag_reg;
    endproperty
    a_flag: assert property (p_flag) else $error("event flag not set");
    property p_zero;
        @(posedge clk_sys) disable iff (reset)
            (ctrlWrite && pwdata[5:0] == 6'h00) |=> !cmpLatch_reg;
    endproperty
    a_zero: assert property (p_zero) else $error("latch not cleared");
    property p_swint;
        @(posedge clk_sys) disable iff (reset) (act == ACT_SWINT) |=> !pinOwned_reg;
    endproperty
    a_swint: assert property (p_swint) else $error("pin taken in swint");
    property p_trig;
        @(posedge clk_sys) disable iff (reset) (matchRise && act == ACT_TRIGGER) |=> trigger_reg;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger late");
    property p_noovf;
        @(posedge clk_sys) disable iff (reset) timerOneReset |-> !timerOneOverflowSet;
    endproperty
    a_noovf: assert property (p_noovf) else $error("overflow flag set");
    property p_cancel;
        @(posedge clk_sys) disable iff (reset)
            (resetPending_reg && !match && !matchRise) |=> !timerOneReset_reg;
    endproperty
    a_cancel: assert property (p_cancel) else $error("reset not cancelled");
    property p_load;
        @(posedge clk_sys) disable iff (reset)
            (act == ACT_PWM && tbi.periodEnd) |=> dutyActive == $past(dutyNew);
    endproperty
    a_load: assert property (p_load) else $error("duty not loaded");
    property p_hold;
        @(posedge clk_sys) disable iff (reset)
            (act == ACT_PWM && !tbi.periodEnd && $stable(act)) |=> $stable(matchHigh_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("duty changed mid period");
    property p_clr;
        @(posedge clk_sys) disable iff (reset)
            (act == ACT_PWM && tbi.run && !tbi.periodEnd && timeBase == dutyActive)
            |=> !pwmPin_reg;
    endproperty
    a_clr: assert property (p_clr) else $error("pin not cleared at duty");
    c_trig: cover property (@(posedge clk_sys) timerOneReset_reg);
    c_toggle: cover property (@(posedge clk_sys) matchRise && act == ACT_TOGGLE);
    c_pwm: cover property (@(posedge clk_sys) tbi.periodEnd && dutyNew != 10'h000);
endmodule // compare_and_pwm_unit

// ==== verification/pin_load_model.sv ====
`timescale 1ns/1ps
//----------------------------------------
// load on the unit's output pin
//----------------------------------------
module pin_load_model (
    input wire logic clk_sys,
    input wire logic pinOut,
    input wire logic pinOwned,
    input wire logic portLatch,
    output logic pinLevel,
    output int highCycles,
    output int periodCycles
);
    logic prevLevel = 1'b0;
    int highRun = 0;
    int sinceRise = 0;
    // pin configured as output; port latch drives it when unit lets go
    assign pinLevel = pinOwned ? pinOut : portLatch;
    // periods measured rise to rise, high time rise to fall, so a lost first period does no harm
    always @(posedge clk_sys) begin
        prevLevel <= pinLevel;
        sinceRise <= sinceRise + 1;
        highRun <= pinLevel ? highRun + 1 : 0;
        if (pinLevel && !prevLevel) begin
            periodCycles <= sinceRise;
            sinceRise <= 1;
        end
        if (!pinLevel && prevLevel) begin
            highCycles <= highRun;
        end
    end
endmodule // pin_load_model

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
//----------------------------------------
// bench for compare and pwm unit
//----------------------------------------
module testbench;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [15:0] count = 16'h0000;
    logic timerOneTick = 1'b0;
    logic converterEnable = 1'b0;
    logic timerOneReset, timerOneOverflowSet, converterGo, unitEvent, pinOut, pinOwned;
    logic portLatch = 1'b0;
    logic pinLevel;
    int highCycles, periodCycles;
    logic [31:0] q;
    logic err;
    int num_errors = 0;
    int checks = 0;
    int rstCount = 0;

    always #2 clk_sys = ~clk_sys;

    always @(posedge clk_sys) begin
        if (timerOneReset === 1'b1) rstCount <= rstCount + 1;
    end

    compare_and_pwm_unit #(.SECOND_UNIT(1'b1)) i_compare_and_pwm_unit (
        .clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .timerOneCount(count),
        .timerOneTick(timerOneTick), .converterEnable(converterEnable),
        .timerOneReset(timerOneReset), .timerOneOverflowSet(timerOneOverflowSet),
        .converterGo(converterGo), .unitEvent(unitEvent), .pinOut(pinOut),
        .pinOwned(pinOwned)
    );

    pin_load_model i_pin_load_model (
        .clk_sys(clk_sys), .pinOut(pinOut), .pinOwned(pinOwned), .portLatch(portLatch),
        .pinLevel(pinLevel), .highCycles(highCycles), .periodCycles(periodCycles)
    );

    //----------------------------------------
    // shared tasks
    //----------------------------------------
    task print_verdict;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // request held until the edge that samples pready high; data taken there
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            num_errors++;
            print_verdict();
        end
        q = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // timer one advances off the instruction clock, never the system clock
    task pulse_tick;
        timerOneTick <= 1'b1;
        @(posedge clk_sys);
        timerOneTick <= 1'b0;
        @(posedge clk_sys);
    endtask

    task high_for(input int n, output int h);
        h = 0;
        repeat (n) begin
            @(negedge clk_sys);
            if (pinLevel === 1'b1) h++;
        end
        @(posedge clk_sys);
    endtask

    //----------------------------------------
    // scenarios
    //----------------------------------------
    task t_reset;
        apb(1'b0, capcmp_pkg::ADDR_UNIT_CONTROL, 32'h0);
        check(q, 32'h0);
        apb(1'b0, capcmp_pkg::ADDR_PERIOD, 32'h0);
        check(q, 32'hff);
        apb(1'b1, 8'h40, 32'h5a);
        check(err, 1'b1);
        apb(1'b0, 8'h40, 32'h0);
        check(q, 32'h0);
        check(pinOwned, 1'b0);
        $display("test reset done");
    endtask

    task cmp_step(input logic [3:0] mode, input logic [15:0] m, input logic expPin);
        apb(1'b1, capcmp_pkg::ADDR_MATCH_LOW, {24'h0, m[7:0]});
        apb(1'b1, capcmp_pkg::ADDR_MATCH_HIGH, {24'h0, m[15:8]});
        apb(1'b1, capcmp_pkg::ADDR_UNIT_CONTROL, {28'h0, mode});
        check(unitEvent, 1'b0);
        count <= m;
        wait_cyc(3);
        check(pinOut, expPin);
        check(pinOwned, mode != capcmp_pkg::MODE_CMP_SWINT);
        check(unitEvent, 1'b1);
        apb(1'b1, capcmp_pkg::ADDR_FLAGS, 32'h1);
        // parked away from every match value, so byte-wise rewrites never hit it
        count <= 16'h5555;
        wait_cyc(2);
    endtask

    task t_compare;
        cmp_step(capcmp_pkg::MODE_CMP_SET, 16'h1234, 1'b1);
        cmp_step(capcmp_pkg::MODE_CMP_CLEAR, 16'hffff, 1'b0);
        cmp_step(capcmp_pkg::MODE_CMP_TOGGLE, 16'h0001, 1'b1);
        cmp_step(capcmp_pkg::MODE_CMP_TOGGLE, 16'h8000, 1'b0);
        cmp_step(capcmp_pkg::MODE_CMP_SET, 16'h00ff, 1'b1);
        apb(1'b1, capcmp_pkg::ADDR_UNIT_CONTROL, 32'h0);
        wait_cyc(2);
        check(pinOut, 1'b0);
        cmp_step(capcmp_pkg::MODE_CMP_SWINT, 16'h0200, 1'b0);
        $display("test compare done");
    endtask

    task t_trigger;
        converterEnable <= 1'b1;
        apb(1'b1, capcmp_pkg::ADDR_MATCH_LOW, 32'h00);
        apb(1'b1, capcmp_pkg::ADDR_MATCH_HIGH, 32'h01);
        apb(1'b1, capcmp_pkg::ADDR_UNIT_CONTROL, {28'h0, capcmp_pkg::MODE_CMP_TRIGGER});
        count <= 16'h0100;
        wait_cyc(3);
        check(pinOwned, 1'b0);
        check(converterGo, 1'b1);
        check(rstCount, 0);
        pulse_tick();
        wait_cyc(2);
        check(rstCount, 1);
        check(timerOneOverflowSet, 1'b0);
        count <= 16'h0000;
        apb(1'b1, capcmp_pkg::ADDR_FLAGS, 32'h3);
        count <= 16'h0100;
        wait_cyc(3);
        apb(1'b1, capcmp_pkg::ADDR_MATCH_LOW, 32'h01);
        pulse_tick();
        wait_cyc(2);
        check(rstCount, 1);
        count <= 16'h0000;
        $display("test trigger done");
    endtask

    task t_pwm;
        int f;
        int h;
        apb(1'b1, capcmp_pkg::ADDR_UNIT_CONTROL, 32'h0);
        apb(1'b1, capcmp_pkg::ADDR_PERIOD, 32'h3);
        apb(1'b1, capcmp_pkg::ADDR_MATCH_LOW, 32'h1);
        apb(1'b1, capcmp_pkg::ADDR_UNIT_CONTROL, {26'h0, 2'b10, capcmp_pkg::MODE_PWM});
        for (int ps = 0; ps < 2; ps++) begin
            f = (ps == 0) ? 1 : 4;
            apb(1'b1, capcmp_pkg::ADDR_TIMER_TWO_CONTROL, 32'h7c | ps);
            wait_cyc(4 * 16 * f);
            check(periodCycles, 4 * capcmp_pkg::OSC_PER_TICK * f);
            check(highCycles, 6 * f);
        end
        apb(1'b0, capcmp_pkg::ADDR_MATCH_HIGH, 32'h0);
        check(q, 32'h1);
        apb(1'b1, capcmp_pkg::ADDR_MATCH_HIGH, 32'h55);
        apb(1'b0, capcmp_pkg::ADDR_MATCH_HIGH, 32'h0);
        check(q, 32'h1);
        apb(1'b1, capcmp_pkg::ADDR_MATCH_LOW, 32'h2);
        wait_cyc(4 * 64);
        check(highCycles, 40);
        apb(1'b0, capcmp_pkg::ADDR_MATCH_HIGH, 32'h0);
        check(q, 32'h2);
        apb(1'b1, capcmp_pkg::ADDR_MATCH_LOW, 32'h0);
        apb(1'b1, capcmp_pkg::ADDR_UNIT_CONTROL, {28'h0, capcmp_pkg::MODE_PWM});
        wait_cyc(128);
        high_for(64, h);
        check(h, 0);
        apb(1'b1, capcmp_pkg::ADDR_MATCH_LOW, 32'hff);
        apb(1'b1, capcmp_pkg::ADDR_UNIT_CONTROL, {26'h0, 2'b11, capcmp_pkg::MODE_PWM});
        wait_cyc(128);
        high_for(64, h);
        check(h, 64);
        portLatch <= 1'b1;
        apb(1'b1, capcmp_pkg::ADDR_UNIT_CONTROL, 32'h0);
        wait_cyc(2);
        check(pinOwned, 1'b0);
        check(pinLevel, 1'b1);
        $display("test pwm done");
    endtask

    initial begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_compare();
        t_trigger();
        t_pwm();
        print_verdict();
    end
endmodule // testbench
